// >>> rsr_defines.svh
// register offset, field positions and reset values of the ramp status word
// assumes inclusion by rsr_ramp_status.sv only
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH

`define RSR_ADDR_W 7
`define RSR_AXIS1_RAMP_STATUS_OFS 7'h60
// field positions
`define RSR_BIT_VSTOP_R 15
`define RSR_BIT_VSTOP_L 14
`define RSR_BIT_STALL_LIVE 13
`define RSR_BIT_SECOND_MOVE 12
`define RSR_BIT_ZWAIT 11
`define RSR_BIT_VZERO 10
`define RSR_BIT_POS_REACHED 9
`define RSR_BIT_VEL_REACHED 8
`define RSR_BIT_EVT_POS 7
`define RSR_BIT_EVT_STALL 6
`define RSR_BIT_EVT_STOP_R 5
`define RSR_BIT_EVT_STOP_L 4
`define RSR_BIT_LATCH_R 3
`define RSR_BIT_LATCH_L 2
`define RSR_BIT_SW_R 1
`define RSR_BIT_SW_L 0
// write-one-to-clear mask: bits 12, 7, 6, 3, 2
`define RSR_W1C_MASK 32'h000010CC
// reset value of every sticky flag
`define RSR_FLAG_RST 1'h0
// reset value of the switch synchronisers
`define RSR_SYNC_RST 3'h0

`endif

// >>> rsr_pkg.sv
// types shared by the ramp status register block
// assumes nothing beyond a SystemVerilog compiler
package rsr_pkg;

  // live motion conditions from the ramp generator, same clock domain
  typedef struct packed {
    logic vstop_r;          // right virtual limit active
    logic vstop_l;          // left virtual limit active
    logic stall_live;       // live stall indication
    logic reversal;         // one-cycle pulse: ramp had to travel back
    logic zero_wait;        // post-stop wait interval running
  } rsr_live_t;

  // stop-event control from the switch-mode and ramp logic
  typedef struct packed {
    logic stop_r_req;       // right stop condition while moving toward it
    logic stop_l_req;       // left stop condition while moving toward it
    logic stop_r_en;        // right stop function enabled
    logic stop_l_en;        // left stop function enabled
    logic hold_mode;        // software selected hold mode
    logic move_neg;         // motion commanded in negative direction
    logic move_pos;         // motion commanded in positive direction
    logic soft_stop;        // soft stop operation selected
    logic toward_r_done;    // motion toward right switch has ended
    logic toward_l_done;    // motion toward left switch has ended
  } rsr_stop_ctl_t;

  // register write port
  typedef struct packed {
    logic wr_en;                // one-cycle write strobe
    logic [6:0] addr;           // register address
    logic [31:0] wdata;         // write data
  } rsr_wr_t;

endpackage

// >>> rsr_ramp_status.sv
// ramp status word of the first axis: live flags, sticky events, interrupt
// assumes a single clk_sys domain; switch pins are asynchronous
// Summary of operation
// - bit 15 shows right virtual limit live
// - bit 14 shows left virtual limit live
// - bit 13 mirrors live stall indication
// - bit 12 sticky on reversal, write-one clears
// - bit 11 reads one during post-stop wait
// - bit 10 reads one at zero speed
// - bit 9 combinational position equals goal
// - bit 8 speed equals top speed setting
// - event bits 7..4 ORed into interrupt
// - stop event withdrawn by hold, reverse or disabled stop; in soft stop only once motion toward the switch ends
// - bits 1,0 show physical switch states
`include "rsr_defines.svh"

module rsr_ramp_status #(
  parameter int POS_W = 32,   // position width
  parameter int VEL_W = 24    // velocity width
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire rsr_pkg::rsr_wr_t wr,
  input wire logic [`RSR_ADDR_W-1:0] rd_addr,
  output logic [31:0] rd_data,
  // ramp generator state
  input wire rsr_pkg::rsr_live_t live,
  input wire logic [POS_W-1:0] current_ramp_position,
  input wire logic [POS_W-1:0] goal_position,
  input wire logic [VEL_W-1:0] current_ramp_speed,
  input wire logic [VEL_W-1:0] top_speed_setting,
  // stop and latch control
  input wire rsr_pkg::rsr_stop_ctl_t stop_ctl,
  input wire logic stall_halt_enable,
  input wire logic latch_r_event,
  input wire logic latch_l_event,
  // physical limit switch pins and polarity (1 = active low)
  input wire logic ref_r_pin,
  input wire logic ref_l_pin,
  input wire logic pol_r_inv,
  input wire logic pol_l_inv,
  // interrupt and sticky stall event outputs
  output logic irq_out,
  output logic stall_halt_event
);

  // live comparisons, no storage on purpose
  logic pos_match;      // position equals goal
  logic vel_match;      // speed equals top speed
  logic vel_zero;       // speed is zero
  logic wr_hit;         // write to the status word
  logic [31:0] clr;     // bits software asks to clear

  assign pos_match = (current_ramp_position == goal_position);
  assign vel_match = (current_ramp_speed == top_speed_setting);
  assign vel_zero = (current_ramp_speed == '0);
  assign wr_hit = wr.wr_en && (wr.addr == `RSR_AXIS1_RAMP_STATUS_OFS);
  // only w1c bits may clear; zeros and read-only bits are dropped
  assign clr = wr_hit ? (wr.wdata & `RSR_W1C_MASK) : 32'h00000000;

  // switch synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [2:0] sync_r_r;
  logic [2:0] sync_l_r;
  logic sw_r_r;         // filtered right pin level
  logic sw_l_r;         // filtered left pin level

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync_r_r <= `RSR_SYNC_RST;
      sync_l_r <= `RSR_SYNC_RST;
    end
    else
    begin
      sync_r_r <= {sync_r_r[1:0], ref_r_pin};
      sync_l_r <= {sync_l_r[1:0], ref_l_pin};
    end
  end

  // filtered level only moves when the last two stages agree
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sw_r_r <= `RSR_FLAG_RST;
      sw_l_r <= `RSR_FLAG_RST;
    end
    else
    begin
      if (sync_r_r[1] == sync_r_r[2])
      begin
        sw_r_r <= sync_r_r[2];
      end
      if (sync_l_r[1] == sync_l_r[2])
      begin
        sw_l_r <= sync_l_r[2];
      end
    end
  end

  // previous position match, for the rising-edge event
  logic pos_match_d_r;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pos_match_d_r <= `RSR_FLAG_RST;
    end
    else
    begin
      pos_match_d_r <= pos_match;
    end
  end

  // software-cleared sticky flags; a set in the clear cycle wins
  logic second_move_r;  // ramp reversal seen
  logic evt_pos_r;      // target reached event
  logic evt_stall_r;    // stall halt event
  logic latch_r_r;      // right latch ready
  logic latch_l_r;      // left latch ready
  logic stall_set;      // stall halt condition

  // stall only raises an event when halting on stall is enabled
  assign stall_set = stall_halt_enable && live.stall_live;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      second_move_r <= `RSR_FLAG_RST;
      evt_pos_r <= `RSR_FLAG_RST;
      evt_stall_r <= `RSR_FLAG_RST;
      latch_r_r <= `RSR_FLAG_RST;
      latch_l_r <= `RSR_FLAG_RST;
    end
    else
    begin
      second_move_r <= live.reversal || (second_move_r && !clr[`RSR_BIT_SECOND_MOVE]);
      evt_pos_r <= (pos_match && !pos_match_d_r) || (evt_pos_r && !clr[`RSR_BIT_EVT_POS]);
      // a stall that is still present in the clear cycle keeps the event set
      evt_stall_r <= stall_set || (evt_stall_r && !clr[`RSR_BIT_EVT_STALL]);
      latch_r_r <= latch_r_event || (latch_r_r && !clr[`RSR_BIT_LATCH_R]);
      latch_l_r <= latch_l_event || (latch_l_r && !clr[`RSR_BIT_LATCH_L]);
    end
  end

  // hardware-managed stop events; read only to software
  logic evt_stop_r_r;
  logic evt_stop_l_r;
  logic stop_r_drop;    // withdraw right stop event
  logic stop_l_drop;    // withdraw left stop event

  // hold mode, reverse command or disabled stop withdraw the event;
  // in soft stop the event also waits for motion toward the switch to end
  always_comb
  begin
    stop_r_drop = stop_ctl.hold_mode || stop_ctl.move_neg || !stop_ctl.stop_r_en;
    stop_l_drop = stop_ctl.hold_mode || stop_ctl.move_pos || !stop_ctl.stop_l_en;
    if (stop_ctl.soft_stop)
    begin
      stop_r_drop = stop_r_drop && stop_ctl.toward_r_done;
      stop_l_drop = stop_l_drop && stop_ctl.toward_l_done;
    end
  end

  // a present stop request always wins over withdrawal
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      evt_stop_r_r <= `RSR_FLAG_RST;
      evt_stop_l_r <= `RSR_FLAG_RST;
    end
    else
    begin
      evt_stop_r_r <= stop_ctl.stop_r_req || (evt_stop_r_r && !stop_r_drop);
      evt_stop_l_r <= stop_ctl.stop_l_req || (evt_stop_l_r && !stop_l_drop);
    end
  end

  // assembled status word; upper half is constant zero
  logic [31:0] status_word;

  always_comb
  begin
    status_word = 32'h00000000;
    status_word[`RSR_BIT_VSTOP_R] = live.vstop_r;
    status_word[`RSR_BIT_VSTOP_L] = live.vstop_l;
    status_word[`RSR_BIT_STALL_LIVE] = live.stall_live;
    status_word[`RSR_BIT_SECOND_MOVE] = second_move_r;
    status_word[`RSR_BIT_ZWAIT] = live.zero_wait;
    status_word[`RSR_BIT_VZERO] = vel_zero;
    status_word[`RSR_BIT_POS_REACHED] = pos_match;
    status_word[`RSR_BIT_VEL_REACHED] = vel_match;
    status_word[`RSR_BIT_EVT_POS] = evt_pos_r;
    status_word[`RSR_BIT_EVT_STALL] = evt_stall_r;
    status_word[`RSR_BIT_EVT_STOP_R] = evt_stop_r_r;
    status_word[`RSR_BIT_EVT_STOP_L] = evt_stop_l_r;
    status_word[`RSR_BIT_LATCH_R] = latch_r_r;
    status_word[`RSR_BIT_LATCH_L] = latch_l_r;
    status_word[`RSR_BIT_SW_R] = sw_r_r ^ pol_r_inv;
    status_word[`RSR_BIT_SW_L] = sw_l_r ^ pol_l_inv;
  end

  // read data is combinational so the live bits are never held stale
  always_comb
  begin
    if (rd_addr == `RSR_AXIS1_RAMP_STATUS_OFS)
    begin
      rd_data = status_word;
    end
    else
    begin
      rd_data = 32'h00000000; // unmapped reads return zero
    end
  end

  // interrupt: OR of the four event bits, cleared with them
  assign irq_out = evt_pos_r || evt_stall_r || evt_stop_r_r || evt_stop_l_r;
  assign stall_halt_event = evt_stall_r;

endmodule

// >>> rsr_ramp_status_chk.sv
// checker for the ramp status word of the first axis
// assumes a bind onto rsr_ramp_status, one clk_sys domain
module rsr_ramp_status_chk #(
  parameter int POS_W = 32,
  parameter int VEL_W = 24
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire rsr_pkg::rsr_wr_t wr,
  input wire logic [6:0] rd_addr,
  input wire logic [31:0] rd_data,
  // ramp state
  input wire rsr_pkg::rsr_live_t live,
  input wire logic [POS_W-1:0] current_ramp_position,
  input wire logic [POS_W-1:0] goal_position,
  input wire logic [VEL_W-1:0] current_ramp_speed,
  input wire logic [VEL_W-1:0] top_speed_setting,
  input wire logic stall_halt_enable,
  // outputs
  input wire logic irq_out,
  input wire logic stall_halt_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // status word selected on the read port
  wire logic sel = rd_addr == 7'h60;
  AST_VLIM: assert property (sel |-> rd_data[15:14] == {live.vstop_r, live.vstop_l})
    else $error("virtual limit bits wrong");
  AST_STALL_LIVE: assert property (sel |-> rd_data[13] == live.stall_live)
    else $error("live stall bit wrong");
  AST_REV: assert property (live.reversal ##1 sel |-> rd_data[12])
    else $error("reversal flag not set");
  AST_ZWAIT: assert property (sel |-> rd_data[11] == live.zero_wait)
    else $error("wait bit wrong");
  AST_VZERO: assert property (sel |-> rd_data[10] == (current_ramp_speed == '0))
    else $error("zero speed bit wrong");
  AST_POS: assert property (sel |-> rd_data[9] == (current_ramp_position == goal_position))
    else $error("position bit wrong");
  AST_VEL: assert property (sel |-> rd_data[8] == (current_ramp_speed == top_speed_setting))
    else $error("speed bit wrong");
  AST_IRQ: assert property (sel |-> irq_out == |rd_data[7:4])
    else $error("irq not the or of events");
  AST_STALL_SET: assert property (stall_halt_enable && live.stall_live |=> irq_out && stall_halt_event)
    else $error("stall event missing");
  AST_KEEP: assert property (stall_halt_event && !(wr.wr_en && wr.addr == 7'h60 && wr.wdata[6]) |=> stall_halt_event)
    else $error("stall event lost");
  AST_UNUSED: assert property (rd_data[31:16] == 16'h0000)
    else $error("upper bits not zero");
  // main scenarios reached
  cover property (live.reversal);
  cover property (stall_halt_event && wr.wr_en);
  cover property ($rose(irq_out));
endmodule

bind rsr_ramp_status rsr_ramp_status_chk #(.POS_W(POS_W), .VEL_W(VEL_W)) u_chk (.clk_sys, .reset, .wr, .rd_addr,
  .rd_data, .live, .current_ramp_position, .goal_position, .current_ramp_speed, .top_speed_setting,
  .stall_halt_enable, .irq_out, .stall_halt_event);

// >>> rsr_ramp_status_tb.sv
// self-checking bench for the ramp status word
// assumes rsr_pkg and the checker are compiled first
module rsr_ramp_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, reset = 1, she = 0, lr = 0, ll = 0, pr = 0, pl = 0, ir = 0, il = 0;
  logic irq_out, stall_halt_event;
  rsr_pkg::rsr_wr_t wr = '0;
  rsr_pkg::rsr_live_t live = '0;
  rsr_pkg::rsr_stop_ctl_t sc = '0;
  logic [6:0] rd_addr = 7'h60;
  logic [31:0] rd_data, cur = '0, goal = '0;
  logic [23:0] spd = '0, top = '0;
  int fail_count = 0, num_checks = 0;
  rsr_ramp_status uut (.clk_sys(clk_sys), .reset(reset), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
    .live(live), .current_ramp_position(cur), .goal_position(goal), .current_ramp_speed(spd),
    .top_speed_setting(top), .stop_ctl(sc), .stall_halt_enable(she), .latch_r_event(lr), .latch_l_event(ll),
    .ref_r_pin(pr), .ref_l_pin(pl), .pol_r_inv(ir), .pol_l_inv(il), .irq_out(irq_out),
    .stall_halt_event(stall_halt_event));
  initial forever #2 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe, returns just after the taking edge
  task automatic wreg(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_sys) wr <= '{1'b1, a, d};
    @(posedge clk_sys) wr.wr_en <= 1'b0;
    #1;
  endtask
  // stop control step, flag seen after the next edge
  task automatic stp(input logic [9:0] v, input logic [31:0] e);
    @(posedge clk_sys) sc <= v;
    @(posedge clk_sys) #1 chk(rd_data, e);
  endtask
  task automatic t_w1c;
    wreg(7'h60, 32'hFFFFEF33);
    chk(rd_data, 32'h780);
    wreg(7'h61, 32'h80);
    chk(rd_data, 32'h780);
    @(posedge clk_sys) rd_addr <= 7'h61;
    #1 chk(rd_data, 32'h0);
    @(posedge clk_sys) rd_addr <= 7'h60;
    wreg(7'h60, 32'h80);
    chk({rd_data[31:1], irq_out}, 32'h700);
    @(posedge clk_sys) goal <= 5;
    $display("w1c done");
  endtask
  task automatic t_live;
    for (int k = 0; k < 5; k++)
      if (k != 1)
      begin
        @(posedge clk_sys) live <= 5'(5'h01 << k);
        #1 chk(rd_data, 32'h500 | (32'h1 << ((k == 0) ? 11 : 11 + k)));
        @(posedge clk_sys) live <= '0;
      end
    $display("live done");
  endtask
  task automatic sp(input logic [23:0] s, t, input logic [31:0] e);
    @(posedge clk_sys) {spd, top} <= {s, t};
    #1 chk(rd_data, e);
  endtask
  task automatic t_pos;
    @(posedge clk_sys) cur <= 5;
    #1 chk(rd_data, 32'h700);
    @(posedge clk_sys) #1 chk({rd_data[31:1], irq_out}, 32'h781);
    wreg(7'h60, 32'h80);
    chk(rd_data, 32'h700);
    @(posedge clk_sys) cur <= 0;
    $display("pos done");
  endtask
  task automatic t_sticky;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys) {live.reversal, lr, ll} <= 3'h4 >> i;
      @(posedge clk_sys) {live.reversal, lr, ll} <= 3'h0;
      wreg(7'h60, 32'h0);
      chk({rd_data[31:1], irq_out}, 32'h500 | ((i == 0) ? 32'h1000 : 32'h10 >> i));
      wreg(7'h60, (i == 0) ? 32'h1000 : 32'h8 >> (i - 1));
      chk(rd_data, 32'h500);
    end
    $display("sticky done");
  endtask
  task automatic t_stall;
    @(posedge clk_sys) {she, live.stall_live} <= 2'h3;
    @(posedge clk_sys) live.stall_live <= 1'b0;
    #1 chk({rd_data[31:2], irq_out, stall_halt_event}, 32'h543);
    wreg(7'h60, 32'h40);
    chk({rd_data[31:1], stall_halt_event}, 32'h500);
    @(posedge clk_sys) she <= 1'b0;
    $display("stall done");
  endtask
  task automatic t_stop;
    stp(10'h28C, 32'h520);
    stp(10'h0A4, 32'h520);
    wreg(7'h60, 32'h20);
    chk(rd_data, 32'h520);
    stp(10'h0A6, 32'h500);
    stp(10'h150, 32'h510);
    stp(10'h050, 32'h510);
    stp(10'h048, 32'h500);
    stp(10'h140, 32'h510);
    stp(10'h000, 32'h500);
    $display("stop done");
  endtask
  task automatic t_pin;
    @(posedge clk_sys) {pr, il} <= 2'h3;
    repeat (3) @(posedge clk_sys);
    #1 chk(rd_data & 32'h2, 32'h0);
    @(posedge clk_sys) #1 chk(rd_data, 32'h503);
    $display("pin done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog, far beyond the 83 or so cycles of the tests
  initial
  begin
    #20000;
    fail_count++;
    stop_test();
  end
  initial
  begin
    repeat (9) @(posedge clk_sys);
    #1 chk(rd_data, 32'h700);
    @(posedge clk_sys) reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_w1c();
    t_live();
    sp(24'h64, 24'h64, 32'h100);
    sp(24'h64, 24'h65, 32'h000);
    sp(24'h00, 24'h00, 32'h500);
    t_pos();
    t_sticky();
    t_stall();
    t_stop();
    t_pin();
    stop_test();
  end
endmodule
